// ### dv/adc_result_format_refsel_tb.sv
// Self-checking bench: APB traffic to the block, behavioural core beside it.
// Assumes one answered access per transfer and sticky done status.
`timescale 1ns/1ps
module adc_result_format_refsel_tb;
  logic                     i_clk, i_resetn, psel, penable, pwrite, go;
  logic                     pready, pslverr, i_start, i_end, o_busy, o_irq;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, rnd;
  logic [7:0]               len;
  logic [1:0]               o_ref_sel;
  logic [32:0]              e_q;
  logic [22:0]              c;
  adc_fmt_pkg::raw_sample_t i_raw, smp;
  adc_fmt_pkg::ref_switch_t o_ref_sw;
  logic [32:0]              exp_q[$];
  int                       mismatches, tests_run;
  // Raw {diff, over, code} and expected 10-bit result
  localparam logic [22:0] CASES [9] = '{
    {2'b00, 11'h000, 10'h000}, {2'b00, 11'h3ff, 10'h3ff},
    {2'b00, 11'h400, 10'h3ff}, {2'b10, 11'h000, 10'h000},
    {2'b10, 11'h7ff, 10'h3ff}, {2'b10, 11'h1ff, 10'h1ff},
    {2'b10, 11'h600, 10'h200}, {2'b11, 11'h000, 10'h1ff},
    {2'b11, 11'h400, 10'h200}};
  localparam logic [2:0] SW [4] = '{3'h4, 3'h2, 3'h0, 3'h1};

  adc_result_format_refsel i_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_start(i_start), .i_end(i_end), .i_raw(i_raw), .o_ref_sw(o_ref_sw),
    .o_ref_sel(o_ref_sel), .o_busy(o_busy), .o_irq(o_irq));
  core_model i_core (.i_clk(i_clk), .i_resetn(i_resetn), .i_go(go),
    .i_len(len), .i_sample(smp), .o_start(i_start), .o_end(i_end),
    .o_raw(i_raw));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  function automatic logic [31:0] pair(input logic [9:0] v, input logic l);
    return l ? {16'h0000, v, 6'h00} : {22'h000000, v};
  endfunction : pair

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic finish_test;
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Idle edge after release keeps psel from being set twice in one step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do
      @(posedge i_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd

  task automatic launch(input logic [12:0] s, input logic [7:0] n);
    int k;
    smp <= s;
    len <= n;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    for (k = 0; k < 20 && o_busy !== 1'b1; k++)
      @(posedge i_clk);
  endtask : launch

  task automatic finish_conv;
    int k;
    for (k = 0; k < 300 && o_busy !== 1'b0; k++)
      @(posedge i_clk);
    repeat (2) @(posedge i_clk);
  endtask : finish_conv

  always @(posedge i_clk)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      e_q = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e_q[32]});
      if (!pwrite)
        chk(prdata, e_q[31:0]);
    end

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial
  begin
    #80000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    mismatches = 0;
    tests_run = 0;
    rnd = 32'hacab3db1;
    {psel, penable, pwrite, go, paddr, pwdata, smp} = '0;
    len = 8'h01;
    i_resetn = 1'b0;
    repeat (4) @(posedge i_clk);
    i_resetn <= 1'b1;
    chk({29'h0, o_ref_sw}, 32'h4);
    rd(adc_fmt_pkg::OFF_SEL, 32'h0);
    rd(adc_fmt_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h024, 32'hffffffff, {1'b1, 32'h0});
    wr(adc_fmt_pkg::OFF_SEL, 32'hffffff3f);
    rd(adc_fmt_pkg::OFF_SEL, 32'h3f);
    for (int r = 0; r < 4; r++)
    begin
      wr(adc_fmt_pkg::OFF_SEL, {24'h0, r[1:0], 6'h00});
      repeat (2) @(posedge i_clk);
      chk({30'h0, o_ref_sel}, {30'h0, r[1:0]});
      chk({29'h0, o_ref_sw}, {29'h0, SW[r]});
    end
    wr(adc_fmt_pkg::OFF_SEL, 32'h0);
    wr(adc_fmt_pkg::OFF_STATUS, 32'h3);
    wr(adc_fmt_pkg::OFF_MASK, 32'h1);
    for (int i = 0; i < 13; i++)
    begin
      rnd = xs(rnd);
      c = (i < 9) ? CASES[i]
                  : {rnd[10], 1'b0, rnd[10] & rnd[9], rnd[9:0], rnd[9:0]};
      launch(c[22:10], {5'h00, rnd[13:11]} + 8'h01);
      finish_conv();
      chk({31'h0, o_irq}, 32'h1);
      rd(adc_fmt_pkg::OFF_STATUS, 32'h1);
      rd(adc_fmt_pkg::OFF_RESULT, pair(c[9:0], 1'b0));
      wr(adc_fmt_pkg::OFF_SEL, 32'h20);
      rd(adc_fmt_pkg::OFF_RESULT, pair(c[9:0], 1'b1));
      wr(adc_fmt_pkg::OFF_SEL, 32'h0);
      wr(adc_fmt_pkg::OFF_STATUS, 32'h1);
      repeat (2) @(posedge i_clk);
      chk({31'h0, o_irq}, 32'h0);
    end
    wr(adc_fmt_pkg::OFF_SEL, 32'h40);
    launch(CASES[5][22:10], 8'h1e);
    wr(adc_fmt_pkg::OFF_SEL, 32'he0);
    repeat (2) @(posedge i_clk);
    chk({30'h0, o_ref_sel}, 32'h1);
    rd(adc_fmt_pkg::OFF_RESULT, pair(c[9:0], 1'b1));
    finish_conv();
    chk({30'h0, o_ref_sel}, 32'h3);
    chk({29'h0, o_ref_sw}, 32'h1);
    rd(adc_fmt_pkg::OFF_RESULT, pair(10'h1ff, 1'b1));
    wr(adc_fmt_pkg::OFF_STATUS, 32'h3);
    wr(adc_fmt_pkg::OFF_MASK, 32'h0);
    launch(CASES[4][22:10], 8'h02);
    finish_conv();
    chk({31'h0, o_irq}, 32'h0);
    rd(adc_fmt_pkg::OFF_STATUS, 32'h1);
    finish_test();
  end
endmodule : adc_result_format_refsel_tb

// ### dv/core_model.sv
// Behavioural analog core: start pulse, conversion span, end pulse.
// Assumes the block's clock and i_go pulsed only while idle.
`timescale 1ns/1ps
module core_model (
  input  wire logic                     i_clk,     // Clock
  input  wire logic                     i_resetn,  // Async reset, low
  input  wire logic                     i_go,      // Begin a conversion
  input  wire logic [7:0]               i_len,     // Span, at least 1
  input  wire adc_fmt_pkg::raw_sample_t i_sample,  // Value to deliver
  output logic                          o_start,   // Start pulse
  output logic                          o_end,     // End pulse
  output adc_fmt_pkg::raw_sample_t      o_raw      // Valid with o_end
);
  logic [7:0] cnt_q;
  // Sample inverted outside the end cycle so a late capture shows up
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q   <= 8'h00;
      o_start <= 1'b0;
      o_end   <= 1'b0;
      o_raw   <= '0;
    end
    else
    begin
      o_start <= i_go && (cnt_q == 8'h00);
      o_end   <= (cnt_q == 8'h01);
      o_raw   <= (cnt_q == 8'h01) ? i_sample : ~i_sample;
      if (i_go && (cnt_q == 8'h00))
        cnt_q <= i_len + 8'h01;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : core_model

// ### logic/adc_fmt_pkg.sv
// Package: register map, field positions, reset values and carrier types
// for the converter result formatting and reference selection block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package adc_fmt_pkg;

  localparam int          RES_W         = 10;
  localparam logic [11:0] OFF_SEL       = 12'h000;
  localparam logic [11:0] OFF_RESULT    = 12'h004;
  localparam logic [11:0] OFF_STATUS    = 12'h008;
  localparam logic [11:0] OFF_MASK      = 12'h00c;
  localparam logic [11:0] OFF_CONV      = 12'h010;
  localparam int          REF_HI        = 7;
  localparam int          REF_LO        = 6;
  localparam int          ALIGN_BIT     = 5;
  localparam int          CHAN_HI       = 4;
  localparam logic [7:0]  SEL_RESET     = 8'h00;
  localparam int          STAT_DONE     = 0;
  localparam int          STAT_REFBAD   = 1;
  localparam logic [1:0]  STAT_RESET    = 2'h0;
  localparam logic [1:0]  REF_EXT_PIN   = 2'h0;
  localparam logic [1:0]  REF_SUPPLY    = 2'h1;
  localparam logic [1:0]  REF_RESERVED  = 2'h2;
  localparam logic [1:0]  REF_INTERNAL  = 2'h3;
  localparam logic [9:0]  DIFF_POS_MAX  = 10'h1ff;
  localparam logic [9:0]  DIFF_NEG_MIN  = 10'h200;
  localparam logic [9:0]  SE_MAX        = 10'h3ff;

  // Reference switch drive toward the analog core
  typedef struct packed {
    logic ext_pin_on;    // External reference pin in use, internal off
    logic supply_on;     // Analog supply switch closed
    logic internal_on;   // Internal bandgap amplifier on
  } ref_switch_t;

  // Raw sample delivered by the core at conversion end
  typedef struct packed {
    logic        diff;      // 1 = differential conversion
    logic        over;      // Differential magnitude at or above full scale
    logic [10:0] code;      // Signed for differential, unsigned in [9:0]
  } raw_sample_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;

endpackage : adc_fmt_pkg

// ### logic/adc_result_format_refsel.sv
// Top of the result formatting and reference selection logic, APB slave.
// Assumes the analog core pulses start and end for each conversion and
// holds the raw sample valid in the end cycle.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module adc_result_format_refsel (
  input  wire logic                     i_clk,      // 250 MHz clock
  input  wire logic                     i_resetn,   // Async reset, low
  input  wire logic                     psel,       // APB select
  input  wire logic                     penable,    // APB enable
  input  wire logic                     pwrite,     // APB write
  input  wire logic [11:0]              paddr,      // APB byte address
  input  wire logic [31:0]              pwdata,     // APB write data
  output logic [31:0]                   prdata,     // APB read data
  output logic                          pready,     // APB ready
  output logic                          pslverr,    // APB error
  input  wire logic                     i_start,    // Core conversion start
  input  wire logic                     i_end,      // Core conversion end
  input  wire adc_fmt_pkg::raw_sample_t i_raw,      // Sample at end
  output adc_fmt_pkg::ref_switch_t      o_ref_sw,   // Reference switches
  output logic [1:0]                    o_ref_sel,  // Active reference
  output logic                          o_busy,     // Conversion running
  output logic                          o_irq       // Interrupt level
);

  logic [7:0]  sel_q;          // Software view of the select register
  logic [7:0]  sel_d;
  logic [1:0]  ref_act_q;      // Reference actually applied
  logic [1:0]  ref_act_d;
  logic [9:0]  code_q;         // Last coded result
  logic [1:0]  stat_q;
  logic [1:0]  stat_d;
  logic [1:0]  mask_q;
  logic [1:0]  mask_d;
  logic [31:0] prdata_d;
  logic        irq_d;
  adc_fmt_pkg::ref_switch_t    sw_d;
  adc_fmt_pkg::ref_switch_t    sw_q;
  adc_fmt_pkg::conv_state_t    st_q;
  adc_fmt_pkg::conv_state_t    st_d;
  logic [9:0]  new_code;
  logic [15:0] pair;

  // Bus decode; slave answers in the first access cycle
  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire wr       = access && pwrite;
  wire rd_setup = setup && !pwrite;
  wire hit_sel  = paddr == adc_fmt_pkg::OFF_SEL;
  wire hit_res  = paddr == adc_fmt_pkg::OFF_RESULT;
  wire hit_stat = paddr == adc_fmt_pkg::OFF_STATUS;
  wire hit_mask = paddr == adc_fmt_pkg::OFF_MASK;
  wire hit_conv = paddr == adc_fmt_pkg::OFF_CONV;
  wire mapped   = hit_sel | hit_res | hit_stat | hit_mask | hit_conv;

  wire done_ev  = (st_q == adc_fmt_pkg::ST_CONV) && i_end;
  wire converting = st_q == adc_fmt_pkg::ST_CONV;

  result_coder u_coder (
    .i_raw  (i_raw),
    .o_code (new_code)
  );

  // Alignment bit is read live from the software view
  result_aligner u_align (
    .i_code (code_q),
    .i_left (sel_q[adc_fmt_pkg::ALIGN_BIT]),
    .o_pair (pair)
  );

  // Conversion tracker
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      adc_fmt_pkg::ST_IDLE:
        if (i_start)
          st_d = adc_fmt_pkg::ST_CONV;
      adc_fmt_pkg::ST_CONV:
        if (i_end)
          st_d = adc_fmt_pkg::ST_DONE;
      adc_fmt_pkg::ST_DONE:
        st_d = i_start ? adc_fmt_pkg::ST_CONV : adc_fmt_pkg::ST_IDLE;
      default:
        st_d = adc_fmt_pkg::ST_IDLE;
    endcase
  end

  assign sel_d = (wr && hit_sel) ? pwdata[7:0] : sel_q;
  // Live selection tracks software outside a conversion, and is picked
  // up in the very end cycle so the next conversion uses it
  assign ref_act_d = (!converting || i_end)
                     ? sel_d[adc_fmt_pkg::REF_HI:adc_fmt_pkg::REF_LO]
                     : ref_act_q;

  // Reserved code drives no switch at all, flagged as an event
  assign sw_d.ext_pin_on  = ref_act_d == adc_fmt_pkg::REF_EXT_PIN;
  assign sw_d.supply_on   = ref_act_d == adc_fmt_pkg::REF_SUPPLY;
  assign sw_d.internal_on = ref_act_d == adc_fmt_pkg::REF_INTERNAL;
  wire refbad_ev = (ref_act_d == adc_fmt_pkg::REF_RESERVED) &&
                   (ref_act_q != adc_fmt_pkg::REF_RESERVED);

  // Set wins over write-one-to-clear
  wire [1:0] clr  = (wr && hit_stat) ? pwdata[1:0] : 2'h0;
  wire [1:0] sets = {refbad_ev, done_ev};
  assign stat_d = (stat_q & ~clr) | sets;
  assign mask_d = (wr && hit_mask) ? pwdata[1:0] : mask_q;
  assign irq_d  = |(stat_d & mask_d);

  // Read data is latched in setup and held through access
  assign prdata_d =
      !rd_setup ? prdata :
      hit_sel   ? {24'h000000, sel_q} :
      hit_res   ? {16'h0000, pair} :
      hit_stat  ? {30'h00000000, stat_q} :
      hit_mask  ? {30'h00000000, mask_q} :
      hit_conv  ? {31'h00000000, converting} :
      32'h00000000;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sel_q     <= adc_fmt_pkg::SEL_RESET;
      ref_act_q <= adc_fmt_pkg::REF_EXT_PIN;
      sw_q      <= 3'b100;
      st_q      <= adc_fmt_pkg::ST_IDLE;
      stat_q    <= adc_fmt_pkg::STAT_RESET;
      mask_q    <= adc_fmt_pkg::STAT_RESET;
      o_irq     <= 1'b0;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else
    begin
      sel_q     <= sel_d;
      ref_act_q <= ref_act_d;
      sw_q      <= sw_d;
      st_q      <= st_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      o_irq     <= irq_d;
      prdata    <= prdata_d;
      pready    <= setup;
      pslverr   <= setup && !mapped;
    end
  end

  // Result loads in the same edge that sets the done flag
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      code_q <= 10'h000;
    else if (done_ev)
      code_q <= new_code;
  end

  assign o_ref_sw  = sw_q;
  assign o_ref_sel = ref_act_q;
  // One-hot code: the conversion state bit is the busy flop itself
  assign o_busy    = st_q[1];

  sequence conv_open;
    st_q == adc_fmt_pkg::ST_CONV && !i_end;
  endsequence

  property ref_locked;
    @(posedge i_clk) disable iff (!i_resetn)
    conv_open |=> $stable(ref_act_q);
  endproperty

  ref_hold_a: assert property (ref_locked)
    else $error("active reference moved during a conversion");

  ref_pickup_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    done_ev |=> ref_act_q == sel_q[adc_fmt_pkg::REF_HI:adc_fmt_pkg::REF_LO])
    else $error("reference not applied at conversion end");

  ref_decode_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    ##1 (sw_q.supply_on == (ref_act_q == adc_fmt_pkg::REF_SUPPLY)) &&
        (sw_q.internal_on == (ref_act_q == adc_fmt_pkg::REF_INTERNAL)))
    else $error("reference switch decode wrong");

  done_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    done_ev |=> stat_q[adc_fmt_pkg::STAT_DONE] && code_q == $past(new_code))
    else $error("done flag or result not updated together");

  left_pair_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    sel_q[adc_fmt_pkg::ALIGN_BIT] |-> pair[5:0] == 6'h00 &&
                                      pair[15:6] == code_q)
    else $error("left aligned layout wrong");

  right_pair_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !sel_q[adc_fmt_pkg::ALIGN_BIT] |-> pair[15:10] == 6'h00 &&
                                       pair[9:0] == code_q)
    else $error("right aligned layout wrong");

  align_now_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (wr && hit_sel) |=> sel_q[adc_fmt_pkg::ALIGN_BIT] ==
                         $past(pwdata[adc_fmt_pkg::ALIGN_BIT]))
    else $error("alignment not updated at once");

  diff_sign_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_raw.diff && !i_raw.over && i_raw.code[10] &&
     $signed(i_raw.code) >= -11'sd512) |-> new_code[9])
    else $error("negative differential lost its sign");

  diff_clamp_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_raw.diff && i_raw.over && !i_raw.code[10]) |->
      new_code == adc_fmt_pkg::DIFF_POS_MAX)
    else $error("positive overrange not clamped");

  se_code_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (!i_raw.diff && !i_raw.code[10]) |-> new_code == i_raw.code[9:0])
    else $error("single-ended code altered");

  diff_code_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_raw.diff && !i_raw.over && $signed(i_raw.code) <= 11'sd511 &&
     $signed(i_raw.code) >= -11'sd512) |-> new_code == i_raw.code[9:0])
    else $error("differential code not two's complement");

  result_read_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (rd_setup && hit_res) |=> prdata[15:0] == $past(pair))
    else $error("result read does not match bytes");

  sequence conv_start;
    st_q != adc_fmt_pkg::ST_CONV && i_start;
  endsequence

  busy_open_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    conv_start |=> o_busy)
    else $error("conversion start not tracked");

  irq_level_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    o_irq == |(stat_q & mask_q))
    else $error("interrupt level disagrees with status");

  done_sticky_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (stat_q[adc_fmt_pkg::STAT_DONE] && !clr[adc_fmt_pkg::STAT_DONE])
      |=> stat_q[adc_fmt_pkg::STAT_DONE])
    else $error("done flag dropped without a clear");

  refbad_set_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    refbad_ev |=> stat_q[adc_fmt_pkg::STAT_REFBAD])
    else $error("reserved reference not flagged");

  ref_idle_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !converting |=> ref_act_q ==
      $past(sel_d[adc_fmt_pkg::REF_HI:adc_fmt_pkg::REF_LO]))
    else $error("idle reference did not follow software");

  ext_switch_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    sw_q.ext_pin_on == (ref_act_q == adc_fmt_pkg::REF_EXT_PIN))
    else $error("external reference switch decode wrong");

  code_hold_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    !done_ev |=> $stable(code_q))
    else $error("result changed outside a conversion end");

  sign_bit_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    i_raw.diff |-> new_code[9] == i_raw.code[10])
    else $error("differential sign bit wrong");

  // A single access cycle per transfer; a stuck ready would double-commit
  ready_pulse_a: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    pready |=> !pready)
    else $error("ready held past the access cycle");

endmodule : adc_result_format_refsel

// ### logic/result_aligner.sv
// Places a 10-bit result into a 16-bit low/high byte pair.
// Pure combinational; alignment follows the select input at once.
`timescale 1ns/1ps
module result_aligner (
  input  wire logic [9:0]  i_code,   // Result code
  input  wire logic        i_left,   // 1 = left aligned
  output logic [15:0]      o_pair    // High byte in [15:8]
);
  assign o_pair = i_left ? {i_code, 6'h00}
                         : {6'h00, i_code};
endmodule : result_aligner

// ### logic/result_coder.sv
// Turns a raw core sample into a 10-bit result code.
// Assumes the core gives signed 11-bit differential values with an over flag.
`timescale 1ns/1ps
module result_coder (
  input  wire adc_fmt_pkg::raw_sample_t i_raw,   // Raw sample
  output logic [9:0]                    o_code   // Coded result
);
  wire signed [10:0] sval = i_raw.code;
  // Clamp both ends of the differential range
  wire pos_sat = i_raw.over && !sval[10] ||
                 (!sval[10] && sval > 11'sd511);
  wire neg_sat = (i_raw.over && sval[10]) ||
                 (sval[10] && sval < -11'sd512);
  wire [9:0] diff_code = pos_sat ? adc_fmt_pkg::DIFF_POS_MAX :
                         neg_sat ? adc_fmt_pkg::DIFF_NEG_MIN :
                         sval[9:0];
  wire [9:0] se_code = i_raw.code[10] ? adc_fmt_pkg::SE_MAX
                                      : i_raw.code[9:0];
  assign o_code = i_raw.diff ? diff_code : se_code;
endmodule : result_coder
